// [logic/rscsp_controller_end.sv]
// Controller end: makes serial clock, shifts words, pulses scan clock
`timescale 1ns/1ps
module rscsp_controller_end (
  input wire logic clk,
  input wire logic rst,
  rscsp_link_if.controller_end link,
  input wire logic send_req,
  input wire rscsp_pkg::rscsp_word_t send_word,
  input wire logic send_is_address,
  input wire logic send_slot0,
  input wire logic scan_req,
  output logic busy,
  output rscsp_pkg::rscsp_word_t reply_word,
  output logic reply_valid
);
  import rscsp_pkg::*;

  // ****************************************
  // Shift engine
  // ****************************************
  typedef enum {CT_IDLE, CT_LOW, CT_HIGH} rscsp_state_t;
  typedef struct packed {
    rscsp_state_t st;
    logic [RSCSP_DIV_W-1:0] div;
    logic [RSCSP_CNT_W-1:0] bit_cnt;
    rscsp_word_t tx;
    rscsp_word_t rx;
    logic sclk;
    logic mosi;
    logic dfa;
    logic sel_n;
    logic scan;
    logic [1:0] miso_sync;
    rscsp_word_t reply;
    logic reply_valid;
    logic busy;
  } rscsp_ctl_t;

  rscsp_ctl_t s;
  rscsp_ctl_t next_s;

  always_comb begin
    next_s = s;
    next_s.reply_valid = 1'b0;
    next_s.scan = scan_req;
    next_s.miso_sync = {s.miso_sync[0], link.serial_line_from_module};
    next_s.div = (s.div == RSCSP_DIV_LAST) ? RSCSP_DIV_RST : s.div + 3'h1;
    case (s.st)
      CT_IDLE: begin
        next_s.sclk = 1'b0;
        if (send_req) begin
          next_s.tx = {send_word[RSCSP_WORD_W-2:0], 1'b0};
          next_s.mosi = send_word[RSCSP_WORD_W-1];
          next_s.dfa = send_is_address;
          next_s.sel_n = ~send_slot0;
          next_s.bit_cnt = RSCSP_CNT_RST;
          next_s.div = RSCSP_DIV_RST;
          next_s.st = CT_LOW;
        end
      end
      CT_LOW: begin
        if (s.div == RSCSP_DIV_LAST) begin
          next_s.sclk = 1'b1;
          next_s.st = CT_HIGH;
        end
      end
      CT_HIGH: begin
        if (s.div == RSCSP_DIV_LAST) begin
          next_s.sclk = 1'b0;
          next_s.rx = {s.rx[RSCSP_WORD_W-2:0], s.miso_sync[1]};
          next_s.bit_cnt = s.bit_cnt + 3'h1;
          next_s.mosi = s.tx[RSCSP_WORD_W-1];
          next_s.tx = {s.tx[RSCSP_WORD_W-2:0], 1'b0};
          if (s.bit_cnt == RSCSP_LAST_BIT) begin
            next_s.reply = {s.rx[RSCSP_WORD_W-2:0], s.miso_sync[1]};
            next_s.reply_valid = 1'b1;
            next_s.st = CT_IDLE;
          end else begin
            next_s.st = CT_LOW;
          end
        end
      end
      default: next_s.st = CT_IDLE;
    endcase
    next_s.busy = (next_s.st != CT_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{st: CT_IDLE, sel_n: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign link.serial_shift_clock = s.sclk;
  assign link.serial_line_to_module = s.mosi;
  assign link.data_or_address_flag = s.dfa;
  assign link.backplane_select_line_n = s.sel_n;
  assign link.scan_clock = s.scan;
  assign busy = s.busy;
  assign reply_word = s.reply;
  assign reply_valid = s.reply_valid;
endmodule

// [logic/rscsp_link_if.sv]
// Rear connector link between controller and module
`timescale 1ns/1ps
interface rscsp_link_if;
  logic serial_shift_clock;
  logic serial_line_to_module;
  logic serial_line_from_module;
  logic data_or_address_flag;
  logic backplane_select_line_n;
  logic scan_clock;
  modport module_end (
    input serial_shift_clock,
    input serial_line_to_module,
    output serial_line_from_module,
    input data_or_address_flag,
    input backplane_select_line_n,
    input scan_clock
  );
  modport controller_end (
    output serial_shift_clock,
    output serial_line_to_module,
    input serial_line_from_module,
    output data_or_address_flag,
    output backplane_select_line_n,
    output scan_clock
  );
endinterface

// [logic/rscsp_module_end.sv]
// Module end: serial shift on link clock, scan multiplexer on system clock
`timescale 1ns/1ps
module rscsp_module_end (
  input wire logic clk,
  input wire logic rst,
  rscsp_link_if.module_end link,
  input wire rscsp_pkg::rscsp_word_t reply_word,
  output rscsp_pkg::rscsp_word_t rx_word,
  output logic rx_is_address,
  output logic rx_slot0,
  output logic rx_valid,
  output rscsp_pkg::rscsp_chan_t mux_channel,
  output logic mux_cold_junction
);
  import rscsp_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  // Shifts a word up by one, new bit at the bottom
  function automatic rscsp_word_t rscsp_shift_word(input rscsp_word_t w, input logic b);
    return {w[RSCSP_WORD_W-2:0], b};
  endfunction

  // Last bit of a word arrives with this count
  function automatic logic rscsp_last_bit(input logic [RSCSP_CNT_W-1:0] c);
    return c == RSCSP_LAST_BIT;
  endfunction

  // Rising level seen past the second synchroniser stage
  function automatic logic rscsp_rose(input logic [2:0] s);
    return s[1] && !s[2];
  endfunction

  // Any level change seen past the second synchroniser stage
  function automatic logic rscsp_toggled(input logic [2:0] s);
    return s[1] != s[2];
  endfunction

  // Next channel of the scan, wrapping after the cold junction
  function automatic rscsp_chan_t rscsp_next_chan(input rscsp_chan_t c);
    rscsp_chan_t n;
    if (c == RSCSP_CH_LAST) begin
      n = RSCSP_CH_FIRST;
    end else begin
      n = c + 5'h01;
    end
    return n;
  endfunction

  // Cold junction sensor is routed on its own channel number
  function automatic logic rscsp_is_cold(input rscsp_chan_t c);
    return c == RSCSP_CH_CJ;
  endfunction

  // ****************************************
  // Link domain state
  // ****************************************
  typedef struct packed {
    rscsp_word_t shift_in;
    rscsp_word_t shift_out;
    logic [RSCSP_CNT_W-1:0] bit_cnt;
    rscsp_word_t hold_word;
    logic hold_addr;
    logic hold_slot0;
    logic word_toggle;
    logic miso;
    rscsp_word_t reply_sync1;
    rscsp_word_t reply_sync2;
  } rscsp_lnk_t;

  rscsp_lnk_t lnk;
  rscsp_lnk_t next_lnk;

  // ****************************************
  // System domain state
  // ****************************************
  typedef struct packed {
    logic [2:0] tog_sync;
    logic [2:0] scan_sync;
    rscsp_word_t reply_hold;
    rscsp_word_t rx_word;
    logic rx_addr;
    logic rx_slot0;
    logic rx_valid;
    rscsp_chan_t chan;
    logic cj;
  } rscsp_sys_t;

  rscsp_sys_t sys;
  rscsp_sys_t next_sys;
  rscsp_word_t reply_src;
  logic word_end;
  logic word_seen;
  logic scan_edge;

  // ****************************************
  // Reply word crossing
  // ****************************************
  // Reply leaves a system flop, so the link side never sees input glitches
  // The user holds the reply stable for at least a word time
  assign reply_src = sys.reply_hold;

  // ****************************************
  // Link domain shifting
  // ****************************************
  assign word_end = rscsp_last_bit(lnk.bit_cnt);

  // Every rising link clock edge moves the input shifter by one bit, and the output shifter on all but a word's last edge
  always_comb begin
    next_lnk = lnk;
    next_lnk.shift_in = rscsp_shift_word(lnk.shift_in, link.serial_line_to_module);
    next_lnk.shift_out = rscsp_shift_word(lnk.shift_out, 1'b0);
    next_lnk.miso = lnk.shift_out[RSCSP_WORD_W-1];
    next_lnk.bit_cnt = lnk.bit_cnt + 3'h1;
    next_lnk.reply_sync1 = reply_src;
    next_lnk.reply_sync2 = lnk.reply_sync1;
    if (word_end) begin
      next_lnk.hold_word = next_lnk.shift_in;
      next_lnk.hold_addr = link.data_or_address_flag;
      next_lnk.hold_slot0 = ~link.backplane_select_line_n;
      // Toggle tells the system side a whole word is held
      next_lnk.word_toggle = ~lnk.word_toggle;
      // Reply loaded here leaves during the next word
      next_lnk.shift_out = lnk.reply_sync2;
    end
  end

  // ****************************************
  // Link domain registers
  // ****************************************
  // Reset is asynchronous because the link clock stops between words
  always_ff @(posedge link.serial_shift_clock or posedge rst) begin
    if (rst) begin
      lnk <= '0;
    end else begin
      lnk <= next_lnk;
    end
  end

  assign link.serial_line_from_module = lnk.miso;

  // ****************************************
  // Word handoff and scan sequencer
  // ****************************************
  assign word_seen = rscsp_toggled(sys.tog_sync);
  assign scan_edge = rscsp_rose(sys.scan_sync);

  // Held word stays stable for a whole word time after the toggle
  always_comb begin
    next_sys = sys;
    next_sys.tog_sync = {sys.tog_sync[1:0], lnk.word_toggle};
    next_sys.scan_sync = {sys.scan_sync[1:0], link.scan_clock};
    next_sys.reply_hold = reply_word;
    next_sys.rx_valid = 1'b0;
    if (word_seen) begin
      next_sys.rx_word = lnk.hold_word;
      next_sys.rx_addr = lnk.hold_addr;
      next_sys.rx_slot0 = lnk.hold_slot0;
      next_sys.rx_valid = 1'b1;
    end
    if (scan_edge) begin
      next_sys.chan = rscsp_next_chan(sys.chan);
    end
    next_sys.cj = rscsp_is_cold(next_sys.chan);
  end

  // ****************************************
  // System domain registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rx_word = sys.rx_word;
  assign rx_is_address = sys.rx_addr;
  assign rx_slot0 = sys.rx_slot0;
  assign rx_valid = sys.rx_valid;
  assign mux_channel = sys.chan;
  assign mux_cold_junction = sys.cj;
endmodule

// [logic/rscsp_pkg.sv]
// Shared constants and types for the rear serial control scan port
package rscsp_pkg;
  localparam int RSCSP_WORD_W = 8;
  localparam int RSCSP_CNT_W = 3;
  localparam logic [RSCSP_CNT_W-1:0] RSCSP_LAST_BIT = 3'h7;
  localparam int RSCSP_CH_W = 5;
  localparam logic [RSCSP_CH_W-1:0] RSCSP_CH_LAST = 5'h10;
  localparam logic [RSCSP_CH_W-1:0] RSCSP_CH_CJ = 5'h10;
  localparam logic [RSCSP_CH_W-1:0] RSCSP_CH_FIRST = 5'h00;
  localparam logic [RSCSP_WORD_W-1:0] RSCSP_WORD_RST = 8'h00;
  localparam logic [RSCSP_CNT_W-1:0] RSCSP_CNT_RST = 3'h0;
  localparam int RSCSP_CLK_DIV = 4;
  localparam int RSCSP_DIV_W = 3;
  localparam logic [RSCSP_DIV_W-1:0] RSCSP_DIV_LAST = 3'(RSCSP_CLK_DIV - 1);
  localparam logic [RSCSP_DIV_W-1:0] RSCSP_DIV_RST = 3'h0;
  typedef logic [RSCSP_WORD_W-1:0] rscsp_word_t;
  typedef logic [RSCSP_CH_W-1:0] rscsp_chan_t;
endpackage

// [tb/rscsp_link_sva.sv]
// Link checker for the rear serial control scan port
`timescale 1ns/1ps
module rscsp_link_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_shift_clock,
  input wire logic serial_line_to_module,
  input wire logic serial_line_from_module,
  input wire logic data_or_address_flag,
  input wire logic backplane_select_line_n,
  input wire logic scan_clock
);
  wire sck = serial_shift_clock;
  wire mo = serial_line_to_module;
  wire sc = scan_clock;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // Link timing
  // ****
  property p_sck_high; $rose(sck) |=> sck [*3]; endproperty
  a_sck_high: assert property (p_sck_high) else $error("sclk high too short");
  property p_sck_low; $fell(sck) |=> !sck [*3]; endproperty
  a_sck_low: assert property (p_sck_low) else $error("sclk low too short");
  property p_mo_setup; $rose(sck) |-> mo == $past(mo, 3); endproperty
  a_mo_setup: assert property (p_mo_setup) else $error("mosi setup");
  property p_mo_hold; sck && $past(sck) |-> $stable(mo); endproperty
  a_mo_hold: assert property (p_mo_hold) else $error("mosi hold");
  property p_fl_hold; sck && $past(sck) |-> $stable(data_or_address_flag); endproperty
  a_fl_hold: assert property (p_fl_hold) else $error("flag hold");
  property p_sl_hold; sck && $past(sck) |-> $stable(backplane_select_line_n); endproperty
  a_sl_hold: assert property (p_sl_hold) else $error("select hold");
  property p_mi_hold; !sck && !$past(sck) |-> $stable(serial_line_from_module); endproperty
  a_mi_hold: assert property (p_mi_hold) else $error("miso hold");
  property p_sc_high; $rose(sc) |=> sc; endproperty
  a_sc_high: assert property (p_sc_high) else $error("scan high short");
  property p_sc_low; $fell(sc) |=> !sc; endproperty
  a_sc_low: assert property (p_sc_low) else $error("scan low short");
endmodule

// [tb/tb_rear_serial_control_scan_port.sv]
// Testbench joining controller end and module end
`timescale 1ns/1ps
module tb_rear_serial_control_scan_port;
  import rscsp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic send_req = 1'b0;
  logic send_is_address = 1'b0;
  logic send_slot0 = 1'b0;
  logic scan_req = 1'b0;
  rscsp_word_t send_word = 8'h00;
  rscsp_word_t reply_in = 8'h00;
  rscsp_word_t last_rep = RSCSP_WORD_RST;
  rscsp_word_t reply_word, rx_word;
  rscsp_chan_t mux_channel;
  logic busy, reply_valid, rx_is_address, rx_slot0, rx_valid, mux_cold_junction;
  int failures = 0;
  int tests_run = 0;
  always #10 clk = ~clk;
  rscsp_link_if link ();
  rscsp_controller_end u_rscsp_controller_end (.clk, .rst, .link(link), .send_req, .send_word,
    .send_is_address, .send_slot0, .scan_req, .busy, .reply_word, .reply_valid);
  rscsp_module_end u_rscsp_module_end (.clk, .rst, .link(link), .reply_word(reply_in), .rx_word,
    .rx_is_address, .rx_slot0, .rx_valid, .mux_channel, .mux_cold_junction);
  rscsp_link_sva u_rscsp_link_sva (.clk, .rst, .serial_shift_clock(link.serial_shift_clock),
    .serial_line_to_module(link.serial_line_to_module),
    .serial_line_from_module(link.serial_line_from_module),
    .data_or_address_flag(link.data_or_address_flag),
    .backplane_select_line_n(link.backplane_select_line_n), .scan_clock(link.scan_clock));
  // ****
  // Checks and scenarios
  // ****
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic send(input rscsp_word_t w, input logic adr, input logic s0,
    input rscsp_word_t rep);
    int n;
    logic prev;
    logic got_rx;
    logic got_rep;
    rscsp_word_t mo;
    rscsp_word_t mi;
    prev = 1'b0;
    got_rx = 1'b0;
    got_rep = 1'b0;
    @(posedge clk);
    send_word <= w;
    send_is_address <= adr;
    send_slot0 <= s0;
    reply_in <= rep;
    send_req <= 1'b1;
    @(posedge clk);
    send_req <= 1'b0;
    for (n = 0; n < 300 && !(got_rx && got_rep && busy === 1'b0); n++) begin
      @(negedge clk);
      if (link.serial_shift_clock !== prev) begin
        if (prev) mi = {mi[6:0], link.serial_line_from_module};
        else mo = {mo[6:0], link.serial_line_to_module};
        prev = ~prev;
      end
      if (n == 0) begin
        chk1(busy, 1'b1);
        chk1(link.data_or_address_flag, adr);
        chk1(link.backplane_select_line_n, ~s0);
      end
      if (rx_valid === 1'b1) begin
        chk(rx_word, w);
        chk1(rx_is_address, adr);
        chk1(rx_slot0, s0);
        got_rx = 1'b1;
      end
      if (reply_valid === 1'b1) begin
        chk(reply_word, last_rep);
        got_rep = 1'b1;
      end
    end
    if (n == 300) begin
      failures++;
      print_verdict();
    end else begin
      chk(mo, w);
      chk(mi, last_rep);
      last_rep = rep;
    end
  endtask
  task automatic scan_all();
    int i;
    rscsp_chan_t exp;
    exp = RSCSP_CH_FIRST;
    chk(8'(mux_channel), 8'(exp));
    for (i = 0; i < 18; i++) begin
      @(posedge clk);
      scan_req <= 1'b1;
      repeat (3) @(posedge clk);
      scan_req <= 1'b0;
      repeat (6) @(negedge clk);
      exp = (exp == RSCSP_CH_LAST) ? RSCSP_CH_FIRST : exp + 5'h01;
      chk(8'(mux_channel), 8'(exp));
      chk1(mux_cold_junction, exp == RSCSP_CH_CJ);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    scan_all();
    send(8'hA5, 1'b0, 1'b0, 8'h3C);
    send(8'h5A, 1'b1, 1'b0, 8'hC3);
    send(8'h01, 1'b0, 1'b1, 8'h80);
    send(8'hFE, 1'b1, 1'b1, 8'h7F);
    print_verdict();
  end
endmodule
